// ### blsu_unit.sv
// Purpose: block load/store and single-fp-op engine of one core
// Assumes: second-level cache answers each word with a one-cycle ack
// Notes: no hazard or ordering checks; ordering is software's job
//
// Behaviour
// - mode-set and media subset run; others trap illegal
// - one fp-class operation in progress per core
// - block load misses primary, allocates second level
// - block ops of different processors run serially
// - software barriers earlier stores before block load
// - store sources not interlocked against earlier loads
// - store sources read one per word, at most every other cycle, execution continues
// - block stores relaxed; loads ordered only by barrier
// - software syncs after block store before state write
// - no load hazard checks; side-effects attribute ignored
// - trap resolves a pending block load
// - no store hazard checks; side-effects attribute ignored
// - overlapping store needs barrier, else contents undefined
// - trap resolves a pending block store
// - block operations relaxed, ordered only by barriers
// - no same-strand dependence check between block ops
// - load destination registers written one per word, at most every other cycle
`timescale 1ns/1ps
module blsu_unit #(
   parameter int FP_LAT = blsu_pkg::FP_LAT_CYC
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   blsu_if.unit lnk,
   output logic l2_req_o,
   output logic l2_we_o,
   output logic [blsu_pkg::ADDR_W-1:0] l2_addr_o,
   output logic [blsu_pkg::DATA_W-1:0] l2_wdata_o,
   output logic l1_alloc_o,
   output logic l2_alloc_o,
   input wire logic l2_ack_i,
   input wire logic [blsu_pkg::DATA_W-1:0] l2_rdata_i
);
   // ****************************************
   // state
   // ****************************************
   typedef enum logic [3:0] {
      S_IDLE = 4'h1,
      S_FP = 4'h2,
      S_LOAD = 4'h4,
      S_STORE = 4'h8
   } blsu_st_t;

   typedef struct packed {
      blsu_st_t st;
      logic [blsu_pkg::CNT_W-1:0] cnt;
      logic [7:0] lat;
      logic [blsu_pkg::VP_W-1:0] vp;
      logic [blsu_pkg::ADDR_W-1:0] base;
      logic [blsu_pkg::REG_W-1:0] reg_base;
      logic req;
      logic we;
      logic [blsu_pkg::ADDR_W-1:0] addr;
      logic [blsu_pkg::DATA_W-1:0] wdata;
      logic illegal;
      logic done;
      logic [blsu_pkg::VP_W-1:0] done_vp;
      logic wr_valid;
      logic [blsu_pkg::REG_W-1:0] wr_idx;
      logic [blsu_pkg::DATA_W-1:0] wr_data;
   } blsu_state_t;

   blsu_state_t s_r;
   blsu_state_t s_nxt;

   function automatic logic [blsu_pkg::ADDR_W-1:0] word_addr(
      input logic [blsu_pkg::ADDR_W-1:0] base,
      input logic [blsu_pkg::CNT_W-1:0] cnt
   );
      word_addr = base + ({{(blsu_pkg::ADDR_W-blsu_pkg::CNT_W){1'b0}}, cnt} * blsu_pkg::WORD_BYTES);
   endfunction

   function automatic logic [blsu_pkg::REG_W-1:0] word_reg(
      input logic [blsu_pkg::REG_W-1:0] base,
      input logic [blsu_pkg::CNT_W-1:0] cnt
   );
      word_reg = base + {{(blsu_pkg::REG_W-blsu_pkg::CNT_W){1'b0}}, cnt};
   endfunction

   localparam logic [7:0] FP_LAST = 8'(FP_LAT - 1);
   localparam logic [blsu_pkg::CNT_W-1:0] CNT_LAST = blsu_pkg::CNT_W'(blsu_pkg::BLK_WORDS - 1);

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.illegal = 1'b0;
      s_nxt.done = 1'b0;
      s_nxt.wr_valid = 1'b0;
      case (s_r.st)
         S_IDLE: begin
            // one engine for all four processors serialises everything
            if (lnk.iss_valid) begin
               s_nxt.vp = lnk.iss_vp;
               s_nxt.cnt = '0;
               s_nxt.lat = '0;
               s_nxt.base = lnk.iss_addr;
               s_nxt.reg_base = lnk.iss_reg;
               case (lnk.iss_kind)
                  blsu_pkg::K_FPOP, blsu_pkg::K_MEDIA_IMPL, blsu_pkg::K_MODE_SET: begin
                     s_nxt.st = S_FP;
                  end
                  blsu_pkg::K_BLK_LOAD: begin
                     // no compare against pending stores; side effects not consulted
                     s_nxt.st = S_LOAD;
                  end
                  blsu_pkg::K_BLK_STORE: begin
                     s_nxt.st = S_STORE;
                  end
                  default: begin
                     // unimplemented media opcodes go to software emulation
                     s_nxt.illegal = 1'b1;
                     s_nxt.done_vp = lnk.iss_vp;
                  end
               endcase
            end
         end
         S_FP: begin
            if (s_r.lat == FP_LAST) begin
               s_nxt.st = S_IDLE;
               s_nxt.done = 1'b1;
               s_nxt.done_vp = s_r.vp;
            end else begin
               s_nxt.lat = s_r.lat + 8'h1;
            end
         end
         S_LOAD: begin
            if (!s_r.req) begin
               s_nxt.req = 1'b1;
               s_nxt.we = 1'b0;
               s_nxt.addr = word_addr(s_r.base, s_r.cnt);
            end else if (l2_ack_i) begin
               s_nxt.req = 1'b0;
               // one destination register per returned word
               s_nxt.wr_valid = 1'b1;
               s_nxt.wr_idx = word_reg(s_r.reg_base, s_r.cnt);
               s_nxt.wr_data = l2_rdata_i;
               s_nxt.cnt = s_r.cnt + 3'h1;
               if (s_r.cnt == CNT_LAST) begin
                  s_nxt.st = S_IDLE;
                  s_nxt.done = 1'b1;
                  s_nxt.done_vp = s_r.vp;
               end
            end
         end
         S_STORE: begin
            if (!s_r.req) begin
               // source sampled only now: no interlock with older loads
               s_nxt.req = 1'b1;
               s_nxt.we = 1'b1;
               s_nxt.addr = word_addr(s_r.base, s_r.cnt);
               s_nxt.wdata = lnk.rd_data;
            end else if (l2_ack_i) begin
               s_nxt.req = 1'b0;
               s_nxt.cnt = s_r.cnt + 3'h1;
               if (s_r.cnt == CNT_LAST) begin
                  // completion is reported regardless of memory model
                  s_nxt.st = S_IDLE;
                  s_nxt.done = 1'b1;
                  s_nxt.done_vp = s_r.vp;
               end
            end
         end
         default: begin
            s_nxt.st = S_IDLE;
         end
      endcase
      // a trap drops the block op so the handler sees nothing in flight
      if (lnk.trap && (s_r.st == S_LOAD || s_r.st == S_STORE)) begin
         s_nxt.st = S_IDLE;
         s_nxt.req = 1'b0;
         s_nxt.wr_valid = 1'b0;
         s_nxt.done = 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_r <= '0;
         s_r.st <= S_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign lnk.iss_ready = (s_r.st == S_IDLE);
   assign lnk.busy = (s_r.st != S_IDLE);
   assign lnk.illegal = s_r.illegal;
   assign lnk.done = s_r.done;
   assign lnk.done_vp = s_r.done_vp;
   assign lnk.wr_valid = s_r.wr_valid;
   assign lnk.wr_idx = s_r.wr_idx;
   assign lnk.wr_data = s_r.wr_data;
   assign lnk.rd_idx = word_reg(s_r.reg_base, s_r.cnt);
   assign l2_req_o = s_r.req;
   assign l2_we_o = s_r.we;
   assign l2_addr_o = s_r.addr;
   assign l2_wdata_o = s_r.wdata;
   // block loads never fill the primary cache, always the second level
   assign l1_alloc_o = 1'b0;
   assign l2_alloc_o = s_r.req && !s_r.we;
endmodule

// ### blsu_pkg.sv
// Purpose: shared constants and types of the block load/store unit
// Assumes: one core clock, four virtual processors per core
// Notes: both ends and the interface use these by scoped name
package blsu_pkg;
   localparam int DATA_W = 64;
   localparam int ADDR_W = 40;
   localparam int REG_W = 5;
   localparam int VP_W = 2;
   localparam int BLK_WORDS = 8;
   localparam int CNT_W = 3;
   localparam int KIND_W = 3;
   // bytes per block word, used to step the address
   localparam logic [ADDR_W-1:0] WORD_BYTES = 40'h8;
   // occupancy time of a plain fp or media op, in ns, rounded up to core cycles
   localparam int FP_LAT_NS = 20;
   localparam int CLK_PERIOD_NS = 5;
   localparam int FP_LAT_CYC = (FP_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [KIND_W-1:0] {
      K_FPOP = 3'h0,
      K_MEDIA_IMPL = 3'h1,
      K_MODE_SET = 3'h2,
      K_MEDIA_UNIMPL = 3'h3,
      K_BLK_LOAD = 3'h4,
      K_BLK_STORE = 3'h5,
      K_SYNC = 3'h6
   } blsu_kind_t;
endpackage

// ### blsu_if.sv
// Purpose: link between the core pipeline and the block load/store unit
// Assumes: both ends on mclk_i
// Notes: rd_idx/rd_data is a same-cycle register read path
`timescale 1ns/1ps
interface blsu_if;
   logic iss_valid;
   logic iss_ready;
   blsu_pkg::blsu_kind_t iss_kind;
   logic [blsu_pkg::VP_W-1:0] iss_vp;
   logic [blsu_pkg::ADDR_W-1:0] iss_addr;
   logic [blsu_pkg::REG_W-1:0] iss_reg;
   logic trap;
   logic illegal;
   logic done;
   logic [blsu_pkg::VP_W-1:0] done_vp;
   logic busy;
   logic wr_valid;
   logic [blsu_pkg::REG_W-1:0] wr_idx;
   logic [blsu_pkg::DATA_W-1:0] wr_data;
   logic [blsu_pkg::REG_W-1:0] rd_idx;
   logic [blsu_pkg::DATA_W-1:0] rd_data;

   modport unit (
      input iss_valid, iss_kind, iss_vp, iss_addr, iss_reg, trap, rd_data,
      output iss_ready, illegal, done, done_vp, busy, wr_valid, wr_idx, wr_data, rd_idx
   );
   modport pipe (
      output iss_valid, iss_kind, iss_vp, iss_addr, iss_reg, trap, rd_data,
      input iss_ready, illegal, done, done_vp, busy, wr_valid, wr_idx, wr_data, rd_idx
   );
endinterface

// ### blsu_pipe.sv
// Purpose: core pipeline end: issues ops, holds fp registers, runs barriers
// Assumes: user side is the instruction stream of four processors
// Notes: a sync waits for the unit to go idle before retiring
`timescale 1ns/1ps
module blsu_pipe (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   blsu_if.pipe lnk,
   input wire logic instr_valid_i,
   output logic instr_ready_o,
   input wire blsu_pkg::blsu_kind_t instr_kind_i,
   input wire logic [blsu_pkg::VP_W-1:0] instr_vp_i,
   input wire logic [blsu_pkg::ADDR_W-1:0] instr_addr_i,
   input wire logic [blsu_pkg::REG_W-1:0] instr_reg_i,
   input wire logic trap_i,
   input wire logic rf_we_i,
   input wire logic [blsu_pkg::REG_W-1:0] rf_idx_i,
   input wire logic [blsu_pkg::DATA_W-1:0] rf_data_i,
   output logic [blsu_pkg::DATA_W-1:0] rf_rdata_o,
   output logic done_o,
   output logic illegal_o,
   output logic [blsu_pkg::VP_W-1:0] done_vp_o
);
   typedef struct packed {
      logic done;
      logic illegal;
      logic [blsu_pkg::VP_W-1:0] vp;
      logic [blsu_pkg::DATA_W-1:0] rdata;
   } blsu_pipe_state_t;

   blsu_pipe_state_t s_r;
   blsu_pipe_state_t s_nxt;
   logic [blsu_pkg::DATA_W-1:0] fregs_r [0:(1<<blsu_pkg::REG_W)-1];
   logic is_sync;

   // ****************************************
   // issue and barrier
   // ****************************************
   assign is_sync = (instr_kind_i == blsu_pkg::K_SYNC);
   // a sync retires only once every block op has drained
   assign instr_ready_o = is_sync ? !lnk.busy : lnk.iss_ready;
   assign lnk.iss_valid = instr_valid_i && !is_sync && !trap_i;
   assign lnk.iss_kind = instr_kind_i;
   assign lnk.iss_vp = instr_vp_i;
   assign lnk.iss_addr = instr_addr_i;
   assign lnk.iss_reg = instr_reg_i;
   assign lnk.trap = trap_i;
   // same-cycle read: user writes may race the store, old or new value goes
   assign lnk.rd_data = fregs_r[lnk.rd_idx];

   always_comb begin
      s_nxt = s_r;
      s_nxt.done = lnk.done || (instr_valid_i && is_sync && !lnk.busy);
      s_nxt.illegal = lnk.illegal;
      s_nxt.vp = (lnk.done || lnk.illegal) ? lnk.done_vp : instr_vp_i;
      s_nxt.rdata = fregs_r[rf_idx_i];
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // unit load data has priority over the user write port
   always_ff @(posedge mclk_i) begin
      if (lnk.wr_valid) begin
         fregs_r[lnk.wr_idx] <= lnk.wr_data;
      end else if (rf_we_i) begin
         fregs_r[rf_idx_i] <= rf_data_i;
      end
   end

   assign done_o = s_r.done;
   assign illegal_o = s_r.illegal;
   assign done_vp_o = s_r.vp;
   assign rf_rdata_o = s_r.rdata;
endmodule

// ### blsu_monitor.sv
// Purpose: link checker for the block load/store unit
// Assumes: fp latency left at four cycles
// Notes: sees only the link between pipe and unit
`timescale 1ns/1ps
module blsu_monitor #(
   parameter int FP_LAT = 4
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic iss_valid,
   input wire logic iss_ready,
   input wire blsu_pkg::blsu_kind_t iss_kind,
   input wire logic trap,
   input wire logic illegal,
   input wire logic done,
   input wire logic busy,
   input wire logic wr_valid
);
   localparam int FP_DONE = FP_LAT + 1;
   logic take;
   logic fp_take;
   logic blk_take;
   logic blk_r;
   // any fp-class or block op accepted and not yet finished or aborted
   logic pend_r;
   assign take = iss_valid && iss_ready;
   assign fp_take = take && (iss_kind inside {blsu_pkg::K_FPOP, blsu_pkg::K_MEDIA_IMPL, blsu_pkg::K_MODE_SET});
   assign blk_take = take && (iss_kind inside {blsu_pkg::K_BLK_LOAD, blsu_pkg::K_BLK_STORE});
   // block op in flight, so a trap can be judged as an abort
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         blk_r <= 1'b0;
         pend_r <= 1'b0;
      end else begin
         blk_r <= blk_take || (blk_r && !done && !trap);
         pend_r <= fp_take || blk_take || (pend_r && !done && !(trap && blk_r));
      end
   end
   // ****************
   // assertions
   // ****************
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!arst_n_i);
   AST_UNIMPL_TRAPS: assert property (take && iss_kind == blsu_pkg::K_MEDIA_UNIMPL |=> illegal && !busy)
      else $error("unimplemented media op not refused");
   AST_IMPL_RUNS: assert property (fp_take |=> !illegal)
      else $error("implemented op refused");
   AST_ONE_OP: assert property (take |-> !pend_r || done)
      else $error("second op taken while one in progress");
   AST_FP_OCCUPY: assert property (fp_take |=> busy [*4] ##1 !busy)
      else $error("fp op occupancy wrong");
   AST_FP_LATENCY: assert property (fp_take |-> ##FP_DONE done)
      else $error("fp op done late or early");
   AST_BLK_SERIAL: assert property (blk_take |=> !iss_ready)
      else $error("block op overlapped");
   AST_LOAD_ONE_WORD: assert property (wr_valid |=> !wr_valid)
      else $error("load words written back to back");
   AST_TRAP_ABORT: assert property (trap && blk_r && busy |=> !busy && !done && !wr_valid)
      else $error("trap did not resolve block op");
endmodule

// ### block_load_store_unit_bench.sv
// Purpose: self-checking bench of pipe and unit joined by their link
// Assumes: second-level cache modelled here with random ack delay
// Notes: expected cache words are queued at issue time
`timescale 1ns/1ps
module block_load_store_unit_bench;
   logic mclk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic instr_valid_i = 1'b0;
   logic instr_ready_o, done_o, illegal_o, l2_req_o, l2_we_o, l1_alloc_o, l2_alloc_o;
   blsu_pkg::blsu_kind_t instr_kind_i = blsu_pkg::K_FPOP;
   logic [1:0] instr_vp_i = 2'h0;
   logic [1:0] done_vp_o;
   logic [39:0] instr_addr_i = 40'h0;
   logic [39:0] l2_addr_o;
   logic [4:0] instr_reg_i = 5'h0;
   logic [4:0] rf_idx_i = 5'h0;
   logic trap_i = 1'b0;
   logic rf_we_i = 1'b0;
   logic l2_ack_i = 1'b0;
   logic hold = 1'b0;
   logic [63:0] rf_data_i = 64'h0;
   logic [63:0] l2_rdata_i = 64'h0;
   logic [63:0] rf_rdata_o, l2_wdata_o;
   logic [63:0] ref_rf [32];
   logic [63:0] mem [logic [39:0]];
   // entry: store flag, address, store data or load register
   logic [104:0] q [$];
   logic [104:0] ent;
   int seed = 69;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;
   blsu_if lnk_if();
   blsu_unit u_blsu_unit (.mclk_i, .arst_n_i, .lnk(lnk_if), .l2_req_o, .l2_we_o, .l2_addr_o, .l2_wdata_o,
      .l1_alloc_o, .l2_alloc_o, .l2_ack_i, .l2_rdata_i);
   blsu_pipe u_blsu_pipe (.mclk_i, .arst_n_i, .lnk(lnk_if), .instr_valid_i, .instr_ready_o, .instr_kind_i,
      .instr_vp_i, .instr_addr_i, .instr_reg_i, .trap_i, .rf_we_i, .rf_idx_i, .rf_data_i, .rf_rdata_o, .done_o,
      .illegal_o, .done_vp_o);
   blsu_monitor #(.FP_LAT(4)) u_blsu_monitor (.mclk_i, .arst_n_i, .iss_valid(lnk_if.iss_valid),
      .iss_ready(lnk_if.iss_ready), .iss_kind(lnk_if.iss_kind), .trap(lnk_if.trap), .illegal(lnk_if.illegal),
      .done(lnk_if.done), .busy(lnk_if.busy), .wr_valid(lnk_if.wr_valid));
   // ****************
   // checking and cache model
   // ****************
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      if (failures == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always #2.5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_of_test();
      end
   end
   // the cache acks at random; idle data lines show noise
   always @(posedge mclk_i) begin
      #1;
      l2_ack_i = l2_req_o && !hold && ($random(seed) % 2 != 0);
      l2_rdata_i = {$random(seed), $random(seed)};
      if (l2_ack_i) begin
         ent = q.pop_front();
         check("l2 addr", l2_addr_o, 64'(ent[103:64]));
         check("l2 we", l2_we_o, 64'(ent[104]));
         check("l1 alloc", l1_alloc_o, 64'h0);
         check("l2 alloc", l2_alloc_o, 64'(!ent[104]));
         if (ent[104]) begin
            check("l2 wdata", l2_wdata_o, ent[63:0]);
            mem[ent[103:64]] = ent[63:0];
         end else begin
            if (!mem.exists(ent[103:64])) mem[ent[103:64]] = l2_rdata_i;
            l2_rdata_i = mem[ent[103:64]];
            ref_rf[ent[4:0]] = l2_rdata_i;
         end
      end
   end
   // ****************
   // stimulus
   // ****************
   task automatic wreg(input logic [4:0] i, input logic [63:0] d);
      @(posedge mclk_i);
      #1;
      rf_we_i = 1'b1;
      rf_idx_i = i;
      rf_data_i = d;
      @(posedge mclk_i);
      #1;
      rf_we_i = 1'b0;
      ref_rf[i] = d;
   endtask
   task automatic rreg(input logic [4:0] i);
      @(posedge mclk_i);
      #1;
      rf_idx_i = i;
      @(posedge mclk_i);
      #1;
      check("reg", rf_rdata_o, ref_rf[i]);
   endtask
   task automatic issue(input blsu_pkg::blsu_kind_t k, input logic [1:0] vp, input logic [39:0] a,
      input logic [4:0] r);
      int n;
      logic st;
      logic [4:0] ri;
      st = k == blsu_pkg::K_BLK_STORE;
      for (int j = 0; j < 8; j++) begin
         ri = r + 5'(j);
         if (st || k == blsu_pkg::K_BLK_LOAD) q.push_back({st, a + 40'(8 * j), st ? ref_rf[ri] : 64'(ri)});
      end
      @(posedge mclk_i);
      #1;
      instr_valid_i = 1'b1;
      instr_kind_i = k;
      instr_vp_i = vp;
      instr_addr_i = a;
      instr_reg_i = r;
      n = 0;
      do begin @(negedge mclk_i); n++; end while (!instr_ready_o && n < 300);
      @(posedge mclk_i);
      #1;
      instr_valid_i = 1'b0;
      if (hold) return;
      n = 0;
      do begin @(negedge mclk_i); n++; end while (!(done_o || illegal_o) && n < 300);
      check("illegal", illegal_o, 64'(k == blsu_pkg::K_MEDIA_UNIMPL || k > blsu_pkg::K_SYNC));
      check("done vp", done_vp_o, 64'(vp));
      if (k inside {blsu_pkg::K_FPOP, blsu_pkg::K_MEDIA_IMPL, blsu_pkg::K_MODE_SET}) begin
         check("fp cycles", n, 64'(blsu_pkg::FP_LAT_CYC + 2));
      end
      check("words left", q.size(), 64'h0);
   endtask
   // cache never answers, so the trap meets the op while its first word is still pending
   task automatic abort_op(input blsu_pkg::blsu_kind_t k);
      hold = 1'b1;
      issue(k, 2'h3, 40'h100, 5'h4);
      repeat (4) @(posedge mclk_i);
      #1;
      trap_i = 1'b1;
      @(posedge mclk_i);
      #1;
      trap_i = 1'b0;
      q.delete();
      hold = 1'b0;
      repeat (20) begin
         @(negedge mclk_i);
         check("aborted done", done_o, 64'h0);
      end
      check("ready after trap", instr_ready_o, 64'h1);
   endtask
   initial begin
      logic [39:0] a;
      logic [4:0] r;
      repeat (4) @(posedge mclk_i);
      #1;
      arst_n_i = 1'b1;
      for (int i = 0; i < 32; i++) wreg(5'(i), {$random(seed), $random(seed)});
      for (int i = 0; i < 8; i++) issue(blsu_pkg::blsu_kind_t'(i), 2'($random(seed)), 40'h0, 5'h0);
      // store then load the same block from other processors
      for (int i = 0; i < 12; i++) begin
         a = 40'(($random(seed) & 3) * 64);
         issue(blsu_pkg::K_BLK_STORE, 2'(i), a, 5'($random(seed)));
         // the load must see the stored block, so a barrier sits between them
         issue(blsu_pkg::K_SYNC, 2'(i), 40'h0, 5'h0);
         r = 5'($random(seed));
         issue(blsu_pkg::K_BLK_LOAD, 2'(i + 1), a, r);
         for (int j = 0; j < 8; j++) rreg(r + 5'(j));
      end
      abort_op(blsu_pkg::K_BLK_LOAD);
      abort_op(blsu_pkg::K_BLK_STORE);
      issue(blsu_pkg::K_BLK_LOAD, 2'h0, 40'h40, 5'h1e);
      end_of_test();
   end
endmodule
